// ===== src/occg_defs.svh
// Register offsets, field positions, reset values and timing counts for clock control
`ifndef OCCG_DEFS_SVH
`define OCCG_DEFS_SVH

`define OCCG_ADDR_GATE_1        16'h300c
`define OCCG_ADDR_GATE_2        16'h300d
`define OCCG_ADDR_GATE_3        16'h300e
`define OCCG_ADDR_GATE_4        16'h300f
`define OCCG_ADDR_OSC_CTRL      16'h303e

`define OCCG_RST_GATE_1         8'he7
`define OCCG_RST_GATE_2         8'h3c
`define OCCG_RST_GATE_3         8'h7e
`define OCCG_RST_GATE_4         8'hab
`define OCCG_RST_OSC_CTRL       8'h00

`define OCCG_OSC_ON_BIT         7
`define OCCG_OSC_KEEP_BIT       5
`define OCCG_OSC_OSEL_BIT       4
`define OCCG_OSC_RANGE_BIT      2
`define OCCG_OSC_HGAIN_BIT      1
`define OCCG_OSC_INIT_BIT       0
`define OCCG_OSC_WR_MASK        8'hb6

`define OCCG_GATE1_FTC_BIT      7
`define OCCG_GATE1_FTB_BIT      6
`define OCCG_GATE1_FTA_BIT      5
`define OCCG_GATE1_MTB_BIT      2
`define OCCG_GATE1_MTA_BIT      1
`define OCCG_GATE1_RTC_BIT      0
`define OCCG_GATE1_WR_MASK      8'he7

`define OCCG_OSC_INIT_CYCLES    4096

`endif

// ===== src/occg_pkg.sv
// Types shared by the oscillator control and clock gating block
package occg_pkg;
    typedef struct packed {
        logic [15:0] addr;
        logic [7:0]  wdata;
        logic        wr;
        logic        rd;
    } occg_bus_req_s;

    typedef struct packed {
        logic on;
        logic keep_in_stop;
        logic output_select;
        logic range_high;
        logic high_gain;
    } occg_osc_ctrl_s;

    typedef enum logic [1:0] {
        OCCG_OSC_OFF  = 2'b00,
        OCCG_OSC_INIT = 2'b01,
        OCCG_OSC_RUN  = 2'b10
    } occg_osc_state_e;
endpackage : occg_pkg

// ===== src/occg_top.sv
// Oscillator control/status register and peripheral bus clock gating
// Functional notes
// (RQ1) Oscillator enable bit 7 turns the oscillator on, feeding the external reference clock.
// (RQ2) Stop-enable bit 5 clear stops oscillator in stop; set keeps it if enabled or requested.
// (RQ3) Output select bit 4: 0 picks the external clock pin, 1 the oscillator source.
// (RQ4) Range bit 2: 0 low range 31.25-39.0625kHz, 1 high range 4-20MHz.
// (RQ5) Gain bit 1: 0 low gain, 1 high gain.
// (RQ6) Status bit 0 reads 0 until oscillator initialization cycles complete, then 1.
// (RQ7) Reserved bits 6 and 3 of oscillator register and 4-3 of gate 1 read zero.
// (RQ8) Gate 1 bits 7, 6, 5 enable bus clock to the three flexible timers.
// (RQ9) Gate 1 bits 2, 1 gate the modulo timers, bit 0 the real-time counter.
// (RQ10) Gate registers one and two are 8-bit read/write, reset e7h and 3ch.
// (RQ11) Gate registers three and four are 8-bit read/write, reset 7eh and abh.
// (RQ12) Software disables a peripheral before gating its clock and reinitialises after.
// (RQ13) Each gated peripheral clock switches without glitches or truncated pulses.
//
// Decided for this implementation: the address-and-strobe port.
`include "occg_defs.svh"

module occg_top #(
    parameter int INIT_CYCLES = `OCCG_OSC_INIT_CYCLES
) (
    input  wire logic                   clock_in,
    input  wire logic                   rst_n_in,
    input  wire occg_pkg::occg_bus_req_s bus_in,
    output logic [7:0]                  rdata_out,
    input  wire logic                   stop_mode_in,
    input  wire logic                   clkgen_req_in,
    input  wire logic                   osc_ready_in,
    output occg_pkg::occg_osc_ctrl_s    osc_ctrl_out,
    output logic                        osc_run_out,
    output logic                        ext_reference_clock_en_out,
    output logic [7:0]                  gate_1_en_out,
    output logic [7:0]                  gate_2_en_out,
    output logic [7:0]                  gate_3_en_out,
    output logic [7:0]                  gate_4_en_out
);
    import occg_pkg::*;

    // The init counter is 16 bits wide, so longer start-ups cannot be served
    if (INIT_CYCLES < 1 || INIT_CYCLES > 65535) begin : g_bad_init
        $error("INIT_CYCLES out of range");
    end

    localparam logic [15:0] INIT_LAST = 16'(INIT_CYCLES - 1);

    occg_osc_ctrl_s  osc_ctrl_r;
    occg_osc_state_e osc_state_r;
    logic [15:0]     init_cnt_r;
    logic            osc_init_done_r;
    logic [7:0]      gate_1_r;
    logic [7:0]      gate_2_r;
    logic [7:0]      gate_3_r;
    logic [7:0]      gate_4_r;
    logic            ready_s1_r;
    logic            ready_s2_r;
    logic            ready_s3_r;
    logic            ready_r;
    logic            osc_run_nxt;

    function automatic logic hit(input logic [15:0] a, input logic [15:0] target);
        hit = (a == target);
    endfunction : hit

    // Only writable fields are stored, so reserved bits read back zero
    function automatic logic [7:0] gate_write(input logic [7:0] d, input logic [7:0] mask);
        gate_write = d & mask;
    endfunction : gate_write

    // Oscillator control fields
    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            osc_ctrl_r <= '0;
        end else if (bus_in.wr && hit(bus_in.addr, `OCCG_ADDR_OSC_CTRL)) begin
            osc_ctrl_r.on            <= bus_in.wdata[`OCCG_OSC_ON_BIT];    // RQ1
            osc_ctrl_r.keep_in_stop  <= bus_in.wdata[`OCCG_OSC_KEEP_BIT];  // RQ2
            osc_ctrl_r.output_select <= bus_in.wdata[`OCCG_OSC_OSEL_BIT];  // RQ3
            osc_ctrl_r.range_high    <= bus_in.wdata[`OCCG_OSC_RANGE_BIT]; // RQ4
            osc_ctrl_r.high_gain     <= bus_in.wdata[`OCCG_OSC_HGAIN_BIT]; // RQ5
        end
    end

    // Oscillator run decision, including stop-mode retention
    always_comb begin
        if (stop_mode_in) begin
            osc_run_nxt = osc_ctrl_r.keep_in_stop && (osc_ctrl_r.on || clkgen_req_in); // RQ2
        end else begin
            osc_run_nxt = osc_ctrl_r.on || clkgen_req_in; // RQ1
        end
    end

    // Ready comes from the analogue side; three stages, accepted when last two agree
    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            ready_s1_r <= 1'b0;
            ready_s2_r <= 1'b0;
            ready_s3_r <= 1'b0;
            ready_r    <= 1'b0;
        end else begin
            ready_s1_r <= osc_ready_in;
            ready_s2_r <= ready_s1_r;
            ready_s3_r <= ready_s2_r;
            if (ready_s2_r == ready_s3_r) begin
                ready_r <= ready_s3_r;
            end
        end
    end

    // Initialization sequencer: count cycles after start-up, also waiting for ready
    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            osc_state_r     <= OCCG_OSC_OFF;
            init_cnt_r      <= 16'h0000;
            osc_init_done_r <= 1'b0;
        end else begin
            case (osc_state_r)
                OCCG_OSC_OFF: begin
                    osc_init_done_r <= 1'b0;
                    init_cnt_r      <= 16'h0000;
                    if (osc_run_nxt) begin
                        osc_state_r <= OCCG_OSC_INIT;
                    end
                end
                OCCG_OSC_INIT: begin
                    if (!osc_run_nxt) begin
                        osc_state_r <= OCCG_OSC_OFF;
                    end else if (init_cnt_r == INIT_LAST && ready_r) begin
                        osc_state_r     <= OCCG_OSC_RUN;
                        osc_init_done_r <= 1'b1; // RQ6
                    end else if (init_cnt_r != INIT_LAST) begin
                        init_cnt_r <= init_cnt_r + 16'h0001;
                    end
                end
                OCCG_OSC_RUN: begin
                    if (!osc_run_nxt) begin
                        osc_state_r     <= OCCG_OSC_OFF;
                        osc_init_done_r <= 1'b0; // RQ6
                    end
                end
                default: begin
                    osc_state_r     <= OCCG_OSC_OFF;
                    osc_init_done_r <= 1'b0;
                end
            endcase
        end
    end

    // Gating registers
    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            gate_1_r <= `OCCG_RST_GATE_1; // RQ10
            gate_2_r <= `OCCG_RST_GATE_2; // RQ10
            gate_3_r <= `OCCG_RST_GATE_3; // RQ11
            gate_4_r <= `OCCG_RST_GATE_4; // RQ11
        end else if (bus_in.wr) begin
            if (hit(bus_in.addr, `OCCG_ADDR_GATE_1)) begin
                gate_1_r <= gate_write(bus_in.wdata, `OCCG_GATE1_WR_MASK); // RQ7
            end
            if (hit(bus_in.addr, `OCCG_ADDR_GATE_2)) begin
                gate_2_r <= bus_in.wdata; // RQ10
            end
            if (hit(bus_in.addr, `OCCG_ADDR_GATE_3)) begin
                gate_3_r <= bus_in.wdata; // RQ11
            end
            if (hit(bus_in.addr, `OCCG_ADDR_GATE_4)) begin
                gate_4_r <= bus_in.wdata; // RQ11
            end
        end
    end

    // Gate enables are registered so each changes only right after a bus clock edge;
    // the peripheral's latch-based gate then passes whole pulses only
    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            gate_1_en_out <= `OCCG_RST_GATE_1;
            gate_2_en_out <= `OCCG_RST_GATE_2;
            gate_3_en_out <= `OCCG_RST_GATE_3;
            gate_4_en_out <= `OCCG_RST_GATE_4;
        end else begin
            gate_1_en_out <= gate_1_r; // RQ8 RQ9 RQ13
            gate_2_en_out <= gate_2_r; // RQ13
            gate_3_en_out <= gate_3_r; // RQ13
            gate_4_en_out <= gate_4_r; // RQ13
        end
    end

    // Oscillator outputs
    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            osc_ctrl_out               <= '0;
            osc_run_out                <= 1'b0;
            ext_reference_clock_en_out <= 1'b0;
        end else begin
            osc_ctrl_out               <= osc_ctrl_r; // RQ3 RQ4 RQ5
            osc_run_out                <= osc_run_nxt; // RQ2
            // Reference clock only offered once stable and enabled
            ext_reference_clock_en_out <= osc_ctrl_r.on && osc_init_done_r; // RQ1
        end
    end

    // Read data stand in the cycle after the strobe only; unmapped reads give zero
    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            rdata_out <= 8'h00;
        end else if (bus_in.rd) begin
            if (hit(bus_in.addr, `OCCG_ADDR_OSC_CTRL)) begin
                rdata_out <= {osc_ctrl_r.on, 1'b0, osc_ctrl_r.keep_in_stop, osc_ctrl_r.output_select,
                              1'b0, osc_ctrl_r.range_high, osc_ctrl_r.high_gain, osc_init_done_r}; // RQ6 RQ7
            end else if (hit(bus_in.addr, `OCCG_ADDR_GATE_1)) begin
                rdata_out <= gate_1_r;
            end else if (hit(bus_in.addr, `OCCG_ADDR_GATE_2)) begin
                rdata_out <= gate_2_r;
            end else if (hit(bus_in.addr, `OCCG_ADDR_GATE_3)) begin
                rdata_out <= gate_3_r;
            end else if (hit(bus_in.addr, `OCCG_ADDR_GATE_4)) begin
                rdata_out <= gate_4_r;
            end else begin
                rdata_out <= 8'h00;
            end
        end else begin
            rdata_out <= 8'h00;
        end
    end

endmodule : occg_top

// ===== verification/occg_osc_model.sv
// Crystal oscillator model: ready a fixed time after it is told to run
module occg_osc_model #(
    parameter int START_CYCLES = 6
) (
    input  wire logic clock_in,
    input  wire logic run_in,
    output logic      ready_out
);
    timeunit 1ns;
    timeprecision 1ps;
    int cnt;
    // A stopped crystal gives no clock, so ready falls with run at once
    always @(posedge clock_in) begin
        if (!run_in) cnt <= 0;
        else if (cnt < START_CYCLES) cnt <= cnt + 1;
    end
    assign ready_out = run_in && (cnt == START_CYCLES);
endmodule : occg_osc_model

// ===== verification/occg_chk.sv
// Port assertions for the clock control block
module occg_chk
    import occg_pkg::*;
#(parameter int INIT_CYCLES = 4096) (
    input wire logic           clock_in,
    input wire logic           rst_n_in,
    input wire occg_bus_req_s  bus_in,
    input wire logic [7:0]     rdata_out,
    input wire logic           stop_mode_in,
    input wire logic           clkgen_req_in,
    input wire logic           osc_ready_in,
    input wire occg_osc_ctrl_s osc_ctrl_out,
    input wire logic           osc_run_out,
    input wire logic           ext_reference_clock_en_out,
    input wire logic [7:0]     gate_1_en_out,
    input wire logic [7:0]     gate_2_en_out,
    input wire logic [7:0]     gate_3_en_out,
    input wire logic [7:0]     gate_4_en_out
);
    default clocking @(posedge clock_in); endclocking
    default disable iff (!rst_n_in);
    logic [7:0] wd1_r, wd2_r;
    // Wide enough for the longest start-up the design accepts plus margin
    logic [16:0] run_cnt_r;
    // Write data delayed two cycles to meet outputs that trail the register
    always_ff @(posedge clock_in) begin
        wd1_r <= bus_in.wdata;
        wd2_r <= wd1_r;
    end
    always_ff @(posedge clock_in) begin
        if (!rst_n_in || !osc_run_out) run_cnt_r <= 17'h00000;
        else if (run_cnt_r != 17'h1ffff) run_cnt_r <= run_cnt_r + 17'h00001;
    end
    property p_g1; bus_in.wr && bus_in.addr == 16'h300c |-> ##2 gate_1_en_out == (wd2_r & 8'he7); endproperty
    a_g1: assert property (p_g1) else $error("gate 1 write");
    property p_g2; bus_in.wr && bus_in.addr == 16'h300d |-> ##2 gate_2_en_out == wd2_r; endproperty
    a_g2: assert property (p_g2) else $error("gate 2 write");
    property p_g4; bus_in.rd && bus_in.addr == 16'h300f |=> rdata_out == gate_4_en_out; endproperty
    a_g4: assert property (p_g4) else $error("gate 4 read");
    property p_osc;
        bus_in.wr && bus_in.addr == 16'h303e |-> ##2 osc_ctrl_out == {wd2_r[7], wd2_r[5:4], wd2_r[2:1]};
    endproperty
    a_osc: assert property (p_osc) else $error("osc control");
    property p_run;
        osc_run_out == ((osc_ctrl_out.on || $past(clkgen_req_in))
            && (!$past(stop_mode_in) || osc_ctrl_out.keep_in_stop));
    endproperty
    a_run: assert property (p_run) else $error("osc run");
    property p_ext_on; ext_reference_clock_en_out |-> osc_ctrl_out.on; endproperty
    a_ext_on: assert property (p_ext_on) else $error("ext ref without enable");
    property p_init_min; $rose(ext_reference_clock_en_out) |-> run_cnt_r >= 17'(INIT_CYCLES); endproperty
    a_init_min: assert property (p_init_min) else $error("init too short");
    property p_init_max;
        osc_ctrl_out.on && osc_ready_in && run_cnt_r == 17'(INIT_CYCLES + 36) |-> ext_reference_clock_en_out;
    endproperty
    a_init_max: assert property (p_init_max) else $error("init never done");
    c_g1: cover property (bus_in.wr && bus_in.addr == 16'h300c);
    c_ext: cover property ($rose(ext_reference_clock_en_out));
    c_stop: cover property (stop_mode_in && osc_ctrl_out.keep_in_stop && osc_run_out);
endmodule : occg_chk

bind occg_top occg_chk #(.INIT_CYCLES(INIT_CYCLES)) u_chk (.*);

// ===== verification/testbench.sv
// Bench for register access, gate outputs and oscillator control
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import occg_pkg::*;
    logic           clock_in = 1'b0;
    logic           rst_n_in = 1'b0;
    logic           stop = 1'b0;
    logic           req = 1'b0;
    logic           rdy, run, ext;
    logic [7:0]     rdata, g1, g2, g3, g4, w;
    occg_bus_req_s  bus = '0;
    occg_osc_ctrl_s ctrl;
    int             bad_count = 0;
    int             comparisons = 0;
    logic [7:0]     ov [5] = '{8'ha0, 8'h90, 8'h84, 8'h82, 8'hff};
    logic [7:0]     mk [2] = '{8'hff, 8'h00};
    always #20 clock_in = ~clock_in;
    occg_top #(.INIT_CYCLES(4)) dut (.clock_in(clock_in), .rst_n_in(rst_n_in), .bus_in(bus),
        .rdata_out(rdata), .stop_mode_in(stop), .clkgen_req_in(req), .osc_ready_in(rdy),
        .osc_ctrl_out(ctrl), .osc_run_out(run), .ext_reference_clock_en_out(ext),
        .gate_1_en_out(g1), .gate_2_en_out(g2), .gate_3_en_out(g3), .gate_4_en_out(g4));
    occg_osc_model u_osc (.clock_in(clock_in), .run_in(run), .ready_out(rdy));
    task automatic check(string n, logic [7:0] e, logic [7:0] s);
        comparisons++;
        if (s !== e) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", n, e, s);
        end
    endtask : check
    task automatic wr(logic [15:0] a, logic [7:0] d);
        @(posedge clock_in);
        bus <= '{a, d, 1'b1, 1'b0};
        @(posedge clock_in);
        bus.wr <= 1'b0;
    endtask : wr
    task automatic rd(logic [15:0] a, logic [7:0] e);
        @(posedge clock_in);
        bus <= '{a, 8'h00, 1'b0, 1'b1};
        @(posedge clock_in);
        bus.rd <= 1'b0;
        #1 check("rdata", e, rdata);
    endtask : rd
    task automatic end_sim();
        $display("Comparisons %0d, mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : end_sim
    initial begin
        repeat (4) @(posedge clock_in);
        rst_n_in <= 1'b1;
        rd(16'h300c, 8'he7);
        rd(16'h300d, 8'h3c);
        rd(16'h300e, 8'h7e);
        rd(16'h300f, 8'hab);
        rd(16'h303e, 8'h00);
        $display("Test reset values finished");
        // Gated peripherals are idle here, so no disable is needed before gating
        wr(16'h300c, 8'hff);
        rd(16'h300c, 8'he7);
        for (int i = 0; i < 8; i++) begin
            wr(16'h300c, 8'h01 << i);
            @(posedge clock_in) #1 check("gate_1", (8'h01 << i) & 8'he7, g1);
        end
        foreach (mk[k]) begin
            for (logic [15:0] a = 16'h300d; a <= 16'h300f; a++) begin
                wr(a, a[7:0] ^ mk[k]);
                rd(a, a[7:0] ^ mk[k]);
            end
        end
        check("gate_2", 8'h0d, g2);
        check("gate_3", 8'h0e, g3);
        check("gate_4", 8'h0f, g4);
        // Unmapped place must neither answer nor disturb a gate
        wr(16'h3010, 8'hff);
        rd(16'h3010, 8'h00);
        check("gate_1", 8'h80, g1);
        $display("Test gate registers finished");
        wr(16'h303e, 8'hff);
        rd(16'h303e, 8'hb6);
        foreach (ov[j]) begin
            w = ov[j];
            wr(16'h303e, w);
            @(posedge clock_in) #1 check("osc_ctrl", {3'h0, w[7], w[5:4], w[2:1]}, {3'h0, ctrl});
        end
        for (int i = 0; i < 100 && ext !== 1'b1; i++) @(posedge clock_in) #1;
        check("ext_ref", 8'h01, {7'h0, ext});
        if (ext !== 1'b1) end_sim();
        rd(16'h303e, 8'hb7);
        $display("Test oscillator start finished");
        @(posedge clock_in);
        stop <= 1'b1;
        repeat (3) @(posedge clock_in);
        #1 check("osc_run", 8'h01, {7'h0, run});
        wr(16'h303e, 8'h80);
        repeat (4) @(posedge clock_in);
        #1 check("osc_run", 8'h00, {7'h0, run});
        check("ext_ref", 8'h00, {7'h0, ext});
        rd(16'h303e, 8'h80);
        @(posedge clock_in);
        stop <= 1'b0;
        wr(16'h303e, 8'h00);
        req <= 1'b1;
        repeat (2) @(posedge clock_in);
        #1 check("osc_run", 8'h01, {7'h0, run});
        check("ext_ref", 8'h00, {7'h0, ext});
        @(posedge clock_in);
        req <= 1'b0;
        $display("Test stop mode finished");
        end_sim();
    end
endmodule : testbench
